//--- design/lic_init_regs.sv
// Purpose: SPI-written link pin and I/O setup plus miscellaneous setup
// Assumes: SPI pins and status inputs are synchronous to clock
// Notes:   SPI mode 0, MSB first, exactly 16 clocks per frame
`timescale 1ns/100ps
module lic_init_regs
  import lic_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_b,
  input  wire logic       sclk,
  input  wire logic       cs_b,
  input  wire logic       mosi,
  input  wire logic       init_mode,
  input  wire logic       vdd_ov,
  input  wire logic       vaux_ov,
  input  wire logic       io0_hs_req,
  input  wire logic       io0_ls_req,
  input  wire logic       io1_hs_req,
  input  wire logic       io1_ls_req,
  input  wire logic       low_power,
  input  wire logic       cyc_sense_sel,
  input  wire logic       cyc_active,
  input  wire logic       lp_request,
  input  wire logic       rnd_code_ok,
  input  wire logic       int_event,
  input  wire logic       int_ack,
  input  wire logic       flash_mode,
  input  wire logic       wd_half,
  input  wire logic [1:0] hw_safe_mode,
  output logic            miso_q,
  output logic            miso_oe_q,
  output logic            link_pin1_pullup_q,
  output logic            link_pin1_hsw_q,
  output logic            link_pin2_pullup_q,
  output logic            link_pin2_hsw_q,
  output logic            io0_hs_en_q,
  output logic            io0_ls_en_q,
  output logic            io1_hs_en_q,
  output logic            io1_ls_en_q,
  output logic            keyed_lowpower_entry_q,
  output logic            lp_enter_ok_q,
  output logic            int_b_q,
  output logic            dbg_check_en_q,
  output logic            dbg_mismatch_q,
  output logic [1:0]      safe_mode_q
);
  typedef enum logic [2:0] {
    LIC_SPI_IDLE  = 3'b001,
    LIC_SPI_SHIFT = 3'b010,
    LIC_SPI_OVER  = 3'b100
  } lic_spi_st_e;

  lic_spi_st_e spi_st_q;
  lic_spi_st_e spi_st_d;
  logic [15:0] frame_q;
  logic [4:0]  bit_cnt_q;
  logic [7:0]  tx_q;
  logic        sclk_q;
  logic        cs_b_q;
  logic [7:0]  link_io_q;
  logic [7:0]  misc_q;
  logic        sv_hs_q;
  logic        sv_ls_q;

  // Edge detection on the synchronous SPI inputs
  wire sclk_rise  = sclk && !sclk_q && !cs_b;
  wire sclk_fall  = !sclk && sclk_q && !cs_b;
  wire frame_beg  = cs_b_q && !cs_b;
  wire frame_end  = !cs_b_q && cs_b;
  wire full_frame = (spi_st_q == LIC_SPI_SHIFT) &&
                    (bit_cnt_q == 5'(LIC_FRAME_BITS));
  wire [4:0] addr = frame_q[LIC_ADDR_MSB:LIC_ADDR_LSB];
  wire [1:0] cmd  = frame_q[LIC_CMD_MSB:LIC_CMD_LSB];
  wire par_calc   = ^{frame_q[15:9], frame_q[7:0]};
  wire par_ok     = !misc_q[LIC_PARITY] ||
                    (par_calc == frame_q[LIC_PAR_BIT]);
  wire wr_try     = frame_end && full_frame && (cmd == LIC_CMD_WRITE);
  wire wr_ok      = wr_try && init_mode && par_ok;
  wire wr_link    = wr_ok && (addr == LIC_ADDR_LINK);
  wire wr_misc    = wr_ok && (addr == LIC_ADDR_MISC);
  // Read-back byte is picked once the whole command byte is in
  wire [4:0] addr_early = frame_q[LIC_ADDR_MSB-8:LIC_ADDR_LSB-8];
  wire [7:0] rd_byte = (addr_early == LIC_ADDR_LINK) ? link_io_q :
                       (addr_early == LIC_ADDR_MISC) ? misc_q : 8'h00;
  wire load_tx = sclk_fall && (bit_cnt_q == 5'h08);

  always_comb begin
    spi_st_d = spi_st_q;
    case (spi_st_q)
      LIC_SPI_IDLE:  if (frame_beg) spi_st_d = LIC_SPI_SHIFT;
      LIC_SPI_SHIFT: begin
        if (cs_b) begin
          spi_st_d = LIC_SPI_IDLE;
        end else if (sclk_rise && bit_cnt_q == 5'(LIC_FRAME_BITS)) begin
          spi_st_d = LIC_SPI_OVER; // Long frames are dropped
        end
      end
      LIC_SPI_OVER:  if (cs_b) spi_st_d = LIC_SPI_IDLE;
      default:       spi_st_d = LIC_SPI_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      spi_st_q  <= LIC_SPI_IDLE;
      sclk_q    <= 1'b0;
      cs_b_q    <= 1'b1;
      frame_q   <= 16'h0000;
      bit_cnt_q <= 5'h00;
    end else begin
      spi_st_q <= spi_st_d;
      sclk_q   <= sclk;
      cs_b_q   <= cs_b;
      if (frame_beg) begin
        bit_cnt_q <= 5'h00;
      end else if (sclk_rise && spi_st_q == LIC_SPI_SHIFT) begin
        frame_q   <= {frame_q[14:0], mosi};
        bit_cnt_q <= bit_cnt_q + 5'h01;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tx_q      <= 8'h00;
      miso_q    <= 1'b0;
      miso_oe_q <= 1'b0;
    end else begin
      miso_oe_q <= !cs_b;
      if (cs_b) begin
        miso_q <= 1'b0;
      end else if (load_tx) begin
        miso_q <= rd_byte[7];
        tx_q   <= {rd_byte[6:0], 1'b0};
      end else if (sclk_fall && bit_cnt_q > 5'h08) begin
        miso_q <= tx_q[7];
        tx_q   <= {tx_q[6:0], 1'b0};
      end
    end
  end

  // Both registers clear on power-on reset
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      link_io_q <= LIC_LINK_RST;
      misc_q    <= LIC_MISC_RST;
    end else begin
      if (wr_link) link_io_q <= frame_q[7:0];
      if (wr_misc) misc_q <= frame_q[7:0];
    end
  end

  // Pre-sleep I/O-0 state, frozen once low power is entered
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sv_hs_q <= 1'b0;
      sv_ls_q <= 1'b0;
    end else if (!low_power) begin
      sv_hs_q <= io0_hs_req;
      sv_ls_q <= io0_ls_req;
    end
  end

  wire [1:0] pin1_fn = link_io_q[LIC_PIN1_MSB:LIC_PIN1_LSB];
  wire [1:0] pin2_fn = link_io_q[LIC_PIN2_MSB:LIC_PIN2_LSB];
  wire cyc_on  = low_power && cyc_sense_sel;
  wire cyc_inv = link_io_q[LIC_CYC_INV];
  wire io1_cut = link_io_q[LIC_IO1_OVOFF] && (vdd_ov || vaux_ov);
  wire io1_ok  = link_io_q[LIC_IO1_OEN] && !io1_cut;
  wire io0_ok  = link_io_q[LIC_IO0_OEN];
  wire io0_hs_d = !io0_ok ? 1'b0 :
                  !cyc_on ? io0_hs_req :
                  cyc_active ? sv_hs_q :
                  cyc_inv && sv_ls_q;
  wire io0_ls_d = !io0_ok ? 1'b0 :
                  !cyc_on ? io0_ls_req :
                  cyc_active ? sv_ls_q :
                  cyc_inv && sv_hs_q;
  wire [2:0] dbg = misc_q[LIC_DBG_MSB:LIC_DBG_LSB];
  // 100..111 map to B3, B2, B1, A, encoded as 11, 10, 01, 00
  wire [1:0] safe_d = dbg[2] ? ~dbg[1:0] : hw_safe_mode;
  wire keyed = misc_q[LIC_KEYED];
  wire int_fire = int_event ||
                  (misc_q[LIC_INT_FLASH] && flash_mode && wd_half);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      link_pin1_pullup_q     <= 1'b0;
      link_pin1_hsw_q        <= 1'b0;
      link_pin2_pullup_q     <= 1'b0;
      link_pin2_hsw_q        <= 1'b0;
      io0_hs_en_q            <= 1'b0;
      io0_ls_en_q            <= 1'b0;
      io1_hs_en_q            <= 1'b0;
      io1_ls_en_q            <= 1'b0;
      keyed_lowpower_entry_q <= 1'b0;
      lp_enter_ok_q          <= 1'b0;
      dbg_check_en_q         <= 1'b0;
      dbg_mismatch_q         <= 1'b0;
      safe_mode_q            <= 2'h0;
    end else begin
      link_pin1_pullup_q     <= (pin1_fn == LIC_PIN_PULLUP);
      link_pin1_hsw_q        <= (pin1_fn == LIC_PIN_HSW);
      link_pin2_pullup_q     <= (pin2_fn == LIC_PIN_PULLUP);
      link_pin2_hsw_q        <= (pin2_fn == LIC_PIN_HSW);
      io0_hs_en_q            <= io0_hs_d;
      io0_ls_en_q            <= io0_ls_d;
      io1_hs_en_q            <= io1_ok && io1_hs_req;
      io1_ls_en_q            <= io1_ok && io1_ls_req;
      keyed_lowpower_entry_q <= keyed;
      lp_enter_ok_q <= lp_request && (!keyed || rnd_code_ok);
      dbg_check_en_q         <= dbg[2];
      dbg_mismatch_q         <= dbg[2] && (hw_safe_mode != ~dbg[1:0]);
      safe_mode_q            <= safe_d;
    end
  end

  lic_int_pulse u_int (
    .clock      (clock),
    .rst_b      (rst_b),
    .fire       (int_fire),
    .level_mode (misc_q[LIC_INT_LEVEL]),
    .narrow     (misc_q[LIC_INT_NARROW]),
    .ack        (int_ack),
    .int_b_q    (int_b_q)
  );

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  property p_no_wr_outside;
    !init_mode |=> $stable(link_io_q) && $stable(misc_q);
  endproperty
  a_no_wr_outside: assert property (p_no_wr_outside)
    else $error("register changed outside init mode");
  property p_wr_link;
    wr_try && init_mode && par_ok && addr == LIC_ADDR_LINK
      |=> link_io_q == $past(frame_q[7:0]);
  endproperty
  a_wr_link: assert property (p_wr_link)
    else $error("link io setup write lost");
  property p_wr_misc;
    wr_try && init_mode && par_ok && addr == LIC_ADDR_MISC
      |=> misc_q == $past(frame_q[7:0]);
  endproperty
  a_wr_misc: assert property (p_wr_misc)
    else $error("misc setup write lost");
  property p_ovoff;
    link_io_q[7] && (vdd_ov || vaux_ov) |=> !io1_hs_en_q && !io1_ls_en_q;
  endproperty
  a_ovoff: assert property (p_ovoff)
    else $error("io1 not cut on overvoltage");
  property p_pin2;
    link_io_q[6:5] == 2'h1 |=> link_pin2_pullup_q && !link_pin2_hsw_q;
  endproperty
  a_pin2: assert property (p_pin2)
    else $error("pin2 pull-up code not applied");
  property p_pin1_na;
    link_io_q[4:3] == 2'h3 |=> !link_pin1_pullup_q && !link_pin1_hsw_q;
  endproperty
  a_pin1_na: assert property (p_pin1_na)
    else $error("pin1 unused code drove the pin");
  property p_io1_off;
    !link_io_q[2] |=> !io1_hs_en_q && !io1_ls_en_q;
  endproperty
  a_io1_off: assert property (p_io1_off)
    else $error("io1 driven while disabled");
  property p_io0_off;
    !link_io_q[1] |=> !io0_hs_en_q && !io0_ls_en_q;
  endproperty
  a_io0_off: assert property (p_io0_off)
    else $error("io0 driven while disabled");
  property p_cyc_act;
    io0_ok && cyc_on && cyc_active |=> io0_hs_en_q == $past(sv_hs_q);
  endproperty
  a_cyc_act: assert property (p_cyc_act)
    else $error("io0 active state not restored");
  property p_cyc_off0;
    cyc_on && !cyc_active && !cyc_inv |=> !io0_hs_en_q && !io0_ls_en_q;
  endproperty
  a_cyc_off0: assert property (p_cyc_off0)
    else $error("io0 driven in off time");
  property p_cyc_off1;
    io0_ok && cyc_on && !cyc_active && cyc_inv && sv_hs_q && !sv_ls_q
      |=> io0_ls_en_q && !io0_hs_en_q;
  endproperty
  a_cyc_off1: assert property (p_cyc_off1)
    else $error("io0 opposite driver not set");
  property p_parity;
    wr_try && misc_q[6] && par_calc != frame_q[8] |=> $stable(link_io_q);
  endproperty
  a_parity: assert property (p_parity)
    else $error("bad parity frame was written");
  property p_keyed;
    lp_request && keyed && !rnd_code_ok |=> !lp_enter_ok_q;
  endproperty
  a_keyed: assert property (p_keyed)
    else $error("low power allowed without code");
  property p_safe;
    misc_q[2] ##1 misc_q[2] |-> safe_mode_q == ~$past(misc_q[1:0]);
  endproperty
  a_safe: assert property (p_safe)
    else $error("safe mode override ignored");

  c_wr_link: cover property (wr_link);
  c_wr_misc: cover property (wr_misc);
  c_wr_refused: cover property (wr_try && !init_mode);
  c_cyc_inv: cover property (cyc_on && !cyc_active && cyc_inv);
endmodule

//--- design/lic_int_pulse.sv
// Purpose: Interrupt pin driver, timed low pulse or held low level
// Assumes: fire is a one-cycle request
// Notes:   A request during a running pulse is absorbed by it
`timescale 1ns/100ps
module lic_int_pulse
  import lic_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic fire,
  input  wire logic level_mode,
  input  wire logic narrow,
  input  wire logic ack,
  output logic      int_b_q
);
  typedef enum logic [2:0] {
    LIC_IP_IDLE  = 3'b001,
    LIC_IP_PULSE = 3'b010,
    LIC_IP_HOLD  = 3'b100
  } lic_ip_st_e;

  lic_ip_st_e  st_q;
  lic_ip_st_e  st_d;
  logic [10:0] cnt_q;
  logic [10:0] cnt_d;
  logic [10:0] w_q;
  logic [10:0] low_cnt_q;
  wire  [10:0] width_sel = narrow ? LIC_NARROW_CYC : LIC_WIDE_CYC;
  wire         done      = (cnt_q == 11'h001);

  always_comb begin
    st_d  = st_q;
    cnt_d = 11'h000;
    case (st_q)
      LIC_IP_IDLE: begin
        if (fire && level_mode) begin
          st_d = LIC_IP_HOLD;
        end else if (fire) begin
          st_d  = LIC_IP_PULSE;
          cnt_d = width_sel;
        end
      end
      LIC_IP_PULSE: begin
        cnt_d = cnt_q - 11'h001;
        if (done) begin
          st_d = LIC_IP_IDLE;
        end
      end
      // A new event in the ack cycle keeps the level low
      LIC_IP_HOLD: begin
        if (ack && !fire) begin
          st_d = LIC_IP_IDLE;
        end
      end
      default: st_d = LIC_IP_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_q    <= LIC_IP_IDLE;
      cnt_q   <= 11'h000;
      w_q     <= 11'h000;
      int_b_q <= 1'b1;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      int_b_q <= (st_d == LIC_IP_IDLE);
      if (st_q == LIC_IP_IDLE && fire) begin
        w_q <= width_sel;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      low_cnt_q <= 11'h000;
    end else begin
      low_cnt_q <= int_b_q ? 11'h000 : low_cnt_q + 11'h001;
    end
  end

  property p_pulse_len;
    @(posedge clock) disable iff (!rst_b)
      $rose(int_b_q) && $past(st_q) == LIC_IP_PULSE |-> low_cnt_q == w_q;
  endproperty
  a_pulse_len: assert property (p_pulse_len)
    else $error("interrupt pulse width wrong");

  property p_level_hold;
    @(posedge clock) disable iff (!rst_b)
      st_q == LIC_IP_HOLD && !ack |=> !int_b_q;
  endproperty
  a_level_hold: assert property (p_level_hold)
    else $error("interrupt level released without ack");

  c_pulse: cover property (@(posedge clock) $rose(int_b_q));
endmodule

//--- design/lic_pkg.sv
// Purpose: Shared constants of the link and I/O setup register block
// Assumes: 20 MHz clock, 16-bit SPI frames
// Notes:   Field positions are bit indices inside the data byte
package lic_pkg;
  // Frame layout
  localparam int          LIC_FRAME_BITS = 16;
  localparam int          LIC_CMD_MSB    = 15;
  localparam int          LIC_CMD_LSB    = 14;
  localparam int          LIC_ADDR_MSB   = 13;
  localparam int          LIC_ADDR_LSB   = 9;
  localparam int          LIC_PAR_BIT    = 8;
  localparam logic [1:0]  LIC_CMD_WRITE  = 2'h1;
  localparam logic [4:0]  LIC_ADDR_LINK  = 5'h07;
  localparam logic [4:0]  LIC_ADDR_MISC  = 5'h08;
  localparam logic [7:0]  LIC_LINK_RST   = 8'h00;
  localparam logic [7:0]  LIC_MISC_RST   = 8'h00;
  // Link and I/O setup fields
  localparam int          LIC_IO1_OVOFF  = 7;
  localparam int          LIC_PIN2_MSB   = 6;
  localparam int          LIC_PIN2_LSB   = 5;
  localparam int          LIC_PIN1_MSB   = 4;
  localparam int          LIC_PIN1_LSB   = 3;
  localparam int          LIC_IO1_OEN    = 2;
  localparam int          LIC_IO0_OEN    = 1;
  localparam int          LIC_CYC_INV    = 0;
  // Miscellaneous setup fields
  localparam int          LIC_KEYED      = 7;
  localparam int          LIC_PARITY     = 6;
  localparam int          LIC_INT_LEVEL  = 5;
  localparam int          LIC_INT_NARROW = 4;
  localparam int          LIC_INT_FLASH  = 3;
  localparam int          LIC_DBG_MSB    = 2;
  localparam int          LIC_DBG_LSB    = 0;
  // Link pin function codes
  localparam logic [1:0]  LIC_PIN_OFF    = 2'h0;
  localparam logic [1:0]  LIC_PIN_PULLUP = 2'h1;
  localparam logic [1:0]  LIC_PIN_HSW    = 2'h2;
  // Interrupt pulse timing
  localparam int          LIC_CLK_KHZ    = 20000;
  localparam int          LIC_WIDE_US    = 100;
  localparam int          LIC_NARROW_US  = 25;
  localparam logic [10:0] LIC_WIDE_CYC   =
    11'(LIC_WIDE_US * LIC_CLK_KHZ / 1000);
  localparam logic [10:0] LIC_NARROW_CYC =
    11'(LIC_NARROW_US * LIC_CLK_KHZ / 1000);
endpackage

//--- dv/lic_spi_host.sv
// Purpose: Host SPI master model driving the setup register block
// Assumes: Mode 0, MSB first, 16-bit frames, slow sclk
// Notes:   Read-back byte is sampled just before each of the last 8 rises
`timescale 1ns/100ps
module lic_spi_host
  import lic_pkg::*;
(
  input  wire logic clock,
  input  wire logic miso_q,
  output logic      sclk,
  output logic      cs_b,
  output logic      mosi
);
  initial begin
    sclk = 1'b0;
    cs_b = 1'b1;
    mosi = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask

  // Setting bad flips the parity bit on purpose
  task automatic xfer(input logic [1:0] cmd, input logic [4:0] addr,
                      input logic [7:0] data, input logic par_on,
                      input logic bad, output logic [7:0] rd);
    logic [15:0] f;
    logic        p;
    p = par_on & (^{cmd, addr, data});
    f = {cmd, addr, p ^ bad, data};
    rd = 8'h00;
    @(posedge clock);
    cs_b <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      tick(2);
      mosi <= f[i];
      tick(2);
      sclk <= 1'b1;
      if (i < 8) rd[i] = miso_q;
      tick(2);
      sclk <= 1'b0;
    end
    tick(2);
    cs_b <= 1'b1;
    // Released line shows the inverse so a stale bit is never trusted
    mosi <= ~f[0];
    tick(2);
  endtask
endmodule

//--- dv/tb_top.sv
// Purpose: Self-checking bench of the link, I/O and misc setup block
// Assumes: Fixed seed, host model owns the SPI pins
// Notes:   Flash interrupt is driven through the flash and half inputs
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin \
  fail_count++; \
  $display("CHECK FAILED %s exp %h got %h", nm, ex, got); end end
module tb_top
  import lic_pkg::*;
;
  logic       clock = 1'b0;
  logic       rst_b, init_mode, vdd_ov, vaux_ov;
  logic       io0_hs_req, io0_ls_req, io1_hs_req, io1_ls_req;
  logic       low_power, cyc_sense_sel, cyc_active, lp_request;
  logic       rnd_code_ok, int_event, int_ack, flash_mode, wd_half;
  logic [1:0] hw_safe_mode, safe_mode_q;
  logic       sclk, cs_b, mosi, miso_q, miso_oe_q, int_b_q;
  logic       link_pin1_pullup_q, link_pin1_hsw_q;
  logic       link_pin2_pullup_q, link_pin2_hsw_q;
  logic       io0_hs_en_q, io0_ls_en_q, io1_hs_en_q, io1_ls_en_q;
  logic       keyed_lowpower_entry_q, lp_enter_ok_q;
  logic       dbg_check_en_q, dbg_mismatch_q;
  logic [7:0] link_e, misc_e, r;
  logic [11:0] cnt;
  int         fail_count = 0;
  int         n_tests = 0;
  int         kind;

  wire logic [7:0] pins = {link_pin1_pullup_q, link_pin1_hsw_q,
    link_pin2_pullup_q, link_pin2_hsw_q, io0_hs_en_q, io0_ls_en_q,
    io1_hs_en_q, io1_ls_en_q};
  wire logic [5:0] misc_o = {keyed_lowpower_entry_q, lp_enter_ok_q,
    dbg_check_en_q, dbg_mismatch_q, safe_mode_q};

  lic_init_regs uut (.clock(clock), .rst_b(rst_b), .sclk(sclk),
    .cs_b(cs_b), .mosi(mosi), .init_mode(init_mode), .vdd_ov(vdd_ov),
    .vaux_ov(vaux_ov), .io0_hs_req(io0_hs_req), .io0_ls_req(io0_ls_req),
    .io1_hs_req(io1_hs_req), .io1_ls_req(io1_ls_req),
    .low_power(low_power), .cyc_sense_sel(cyc_sense_sel),
    .cyc_active(cyc_active), .lp_request(lp_request),
    .rnd_code_ok(rnd_code_ok), .int_event(int_event), .int_ack(int_ack),
    .flash_mode(flash_mode), .wd_half(wd_half), .hw_safe_mode(hw_safe_mode),
    .miso_q(miso_q), .miso_oe_q(miso_oe_q),
    .link_pin1_pullup_q(link_pin1_pullup_q),
    .link_pin1_hsw_q(link_pin1_hsw_q),
    .link_pin2_pullup_q(link_pin2_pullup_q),
    .link_pin2_hsw_q(link_pin2_hsw_q), .io0_hs_en_q(io0_hs_en_q),
    .io0_ls_en_q(io0_ls_en_q), .io1_hs_en_q(io1_hs_en_q),
    .io1_ls_en_q(io1_ls_en_q),
    .keyed_lowpower_entry_q(keyed_lowpower_entry_q),
    .lp_enter_ok_q(lp_enter_ok_q), .int_b_q(int_b_q),
    .dbg_check_en_q(dbg_check_en_q), .dbg_mismatch_q(dbg_mismatch_q),
    .safe_mode_q(safe_mode_q));

  lic_spi_host host (.clock(clock), .miso_q(miso_q), .sclk(sclk),
    .cs_b(cs_b), .mosi(mosi));

  always #25 clock = ~clock;

  function automatic logic [7:0] pins_exp();
    logic [1:0] c1, c2;
    logic       off1;
    c1 = link_e[LIC_PIN1_MSB:LIC_PIN1_LSB];
    c2 = link_e[LIC_PIN2_MSB:LIC_PIN2_LSB];
    // Overvoltage shutoff drops both I/O-1 drivers
    off1 = link_e[LIC_IO1_OVOFF] & (vdd_ov | vaux_ov);
    return {c1 == LIC_PIN_PULLUP, c1 == LIC_PIN_HSW, c2 == LIC_PIN_PULLUP,
      c2 == LIC_PIN_HSW, link_e[1] & io0_hs_req, link_e[1] & io0_ls_req,
      link_e[2] & io1_hs_req & ~off1, link_e[2] & io1_ls_req & ~off1};
  endfunction

  function automatic logic [5:0] misc_exp();
    logic dbg;
    dbg = misc_e[LIC_DBG_MSB];
    return {misc_e[LIC_KEYED],
      lp_request & (~misc_e[LIC_KEYED] | rnd_code_ok), dbg,
      dbg & (hw_safe_mode != ~misc_e[1:0]),
      dbg ? ~misc_e[1:0] : hw_safe_mode};
  endfunction

  task automatic close_out();
    if (fail_count == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic settle();
    repeat (4) @(posedge clock);
    #1;
  endtask

  // Sends one frame, then reads the addressed register back
  task automatic put(input logic [1:0] cmd, input logic [4:0] a,
                     input logic [7:0] d, input logic bad,
                     input logic take);
    logic [7:0] rd;
    host.xfer(cmd, a, d, misc_e[LIC_PARITY], bad, rd);
    if (take && a == LIC_ADDR_LINK) link_e = d;
    if (take && a == LIC_ADDR_MISC) misc_e = d;
    host.xfer(2'h0, a, 8'h00, misc_e[LIC_PARITY], 1'b0, rd);
    `CHK("readback", (a == LIC_ADDR_LINK) ? link_e : misc_e, rd)
  endtask

  task automatic chk_out();
    settle();
    `CHK("pins", pins_exp(), pins)
    `CHK("misc", misc_exp(), misc_o)
    `CHK("miso_oe", 1'b0, miso_oe_q)
  endtask

  // With fl set the request comes from the flash half-period path
  task automatic int_run(input logic [7:0] d, input logic [11:0] w,
                         input logic fl);
    put(LIC_CMD_WRITE, LIC_ADDR_MISC, d, 1'b0, 1'b1);
    @(posedge clock);
    if (fl) begin
      {flash_mode, wd_half} <= 2'h3;
    end else begin
      int_event <= 1'b1;
    end
    @(posedge clock);
    {flash_mode, wd_half, int_event} <= 3'h0;
    #1;
    `CHK("int_low", 1'b0, int_b_q)
    cnt = 12'h000;
    while (int_b_q === 1'b0 && cnt < 12'hbb8) begin
      @(posedge clock);
      #1;
      cnt++;
    end
    `CHK("int_width", w, cnt)
  endtask

  initial begin
    #2000000;
    fail_count++;
    close_out();
  end

  initial begin
    {rst_b, vdd_ov, vaux_ov, low_power, cyc_sense_sel} = 5'h00;
    {flash_mode, wd_half} = 2'h0;
    {io0_hs_req, io0_ls_req, io1_hs_req, io1_ls_req} = 4'h0;
    {cyc_active, lp_request, rnd_code_ok, int_event, int_ack} = 5'h00;
    init_mode = 1'b1;
    hw_safe_mode = 2'h0;
    link_e = 8'h00;
    misc_e = 8'h00;
    void'($urandom(32'hbc65));
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    chk_out();
    `CHK("int_idle", 1'b1, int_b_q)
    put(2'h0, LIC_ADDR_LINK, 8'h00, 1'b0, 1'b0);
    put(2'h0, LIC_ADDR_MISC, 8'h00, 1'b0, 1'b0);
    put(LIC_CMD_WRITE, LIC_ADDR_LINK, 8'hff, 1'b0, 1'b1);
    chk_out();
    for (int k = 0; k < 24; k++) begin
      @(posedge clock);
      r = 8'($urandom);
      {io0_hs_req, io1_hs_req} <= {r[0], r[2]};
      io0_ls_req <= r[1] & ~r[0];
      io1_ls_req <= r[3] & ~r[2];
      vdd_ov <= r[4] & r[5];
      vaux_ov <= r[6] & r[7];
      r = 8'($urandom);
      {lp_request, rnd_code_ok, hw_safe_mode} <= r[3:0];
      // Kinds: plain, outside init mode, other command, bad parity
      kind = $urandom % 4;
      init_mode <= (kind != 1);
      put((kind == 2) ? 2'h3 : LIC_CMD_WRITE,
        ($urandom % 2) ? LIC_ADDR_LINK : LIC_ADDR_MISC, 8'($urandom),
        kind == 3,
        kind == 0 || (kind == 3 && !misc_e[LIC_PARITY]));
      init_mode <= 1'b1;
      chk_out();
    end
    for (int v = 0; v < 2; v++) begin
      @(posedge clock);
      {low_power, io0_hs_req, io0_ls_req, cyc_sense_sel, cyc_active} <=
        5'h0b;
      put(LIC_CMD_WRITE, LIC_ADDR_LINK, 8'h02 | 8'(v), 1'b0, 1'b1);
      settle();
      @(posedge clock);
      low_power <= 1'b1;
      io0_hs_req <= 1'b0;
      settle();
      `CHK("cyc_on", 2'h2, {io0_hs_en_q, io0_ls_en_q})
      @(posedge clock);
      cyc_active <= 1'b0;
      settle();
      `CHK("cyc_off", 2'(v), {io0_hs_en_q, io0_ls_en_q})
      @(posedge clock);
      {low_power, cyc_active} <= 2'h1;
    end
    int_run(8'h00, 12'h7d0, 1'b0);
    int_run(8'h10, 12'h1f4, 1'b0);
    int_run(8'h18, 12'h1f4, 1'b1);
    put(LIC_CMD_WRITE, LIC_ADDR_MISC, 8'h20, 1'b0, 1'b1);
    @(posedge clock);
    int_event <= 1'b1;
    @(posedge clock);
    int_event <= 1'b0;
    repeat (8) @(posedge clock);
    #1;
    `CHK("int_held", 1'b0, int_b_q)
    @(posedge clock);
    int_ack <= 1'b1;
    @(posedge clock);
    int_ack <= 1'b0;
    settle();
    `CHK("int_release", 1'b1, int_b_q)
    close_out();
  end
endmodule
